// [rtl/pmcs_pkg.sv]
/*
 * Constants for the power-mode and clock-source controller.
 * Assumes one 40 MHz system clock; oscillators arrive as
 * asynchronous levels from outside the domain.
 */
package pmcs_pkg;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int          CTL_IDLE_BIT   = 7;
    localparam int          CTL_PRIMARY_RUN_MODE    = 3;
    localparam int          CTL_SEL_HI     = 1;
    localparam int          CTL_SEL_LO     = 0;
    localparam int          TMR_RUN_BIT    = 6;
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [1:0]  SEL_PRIMARY    = 2'h0;
    localparam logic [1:0]  SEL_TIMER      = 2'h1;

    // ------------------------------------------------------------
    // Transition timing, in cycles of the source clock
    // ------------------------------------------------------------
    localparam logic [2:0]  OLD_CYCLES     = 3'h2;
    localparam logic [2:0]  NEW_CYCLES     = 3'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMCS_SRC_PRI = 2'h0,
        PMCS_SRC_TMR = 2'h1,
        PMCS_SRC_INT = 2'h2
    } pmcs_src_e;

    typedef enum logic [4:0] {
        PMCS_RUN    = 5'b00001,
        PMCS_OLD    = 5'b00010,
        PMCS_WAIT   = 5'b00100,
        PMCS_NEW    = 5'b01000,
        PMCS_SLEEP  = 5'b10000
    } pmcs_state_e;

endpackage : pmcs_pkg

// [rtl/pmcs_edge_sync.sv]
/*
 * Synchroniser and rising-edge detector for one oscillator input.
 * Assumes the input is asynchronous to clk and slower than clk/2.
 */
`timescale 1ns/1ps
module pmcs_edge_sync (
    input  wire logic clk,        // System clock
    input  wire logic sys_rst,    // Synchronous reset
    input  wire logic osc_in,     // Asynchronous oscillator level
    output logic      osc_rise    // One-cycle pulse per rising edge
);
    logic [2:0] sync_q;
    logic       level_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], osc_in};
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end

    assign osc_rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;

endmodule // pmcs_edge_sync

// [rtl/pmcs_ctrl.sv]
/*
 * Power-mode controller and glitch-free clock-source switcher.
 * Oscillator outputs arrive as asynchronous levels and are sampled
 * on clk; gate enables are issued from flip-flops. Assumes the core
 * pulses sleep_exec once per sleep instruction and wake_req on exit.
 */
`timescale 1ns/1ps

// Behaviour
// - Writing a new clock select starts a switch once timer is enabled or primary ready; internal at once.
// - Only the sleep instruction enters Idle or Sleep; idle bit picks which.
// - Idle bit 0 at sleep: stop CPU, peripherals and all sources; internal stays powered if WDT or monitor.
// - Run clocks CPU and peripherals; 00 primary, 01 timer, 1x internal.
// - Idle bit 1 at sleep: CPU stops, peripherals stay on selected source.
// - Idle bit is sampled afresh at every sleep instruction.
// - Switch pauses two old-source cycles plus three new-source cycles.
// - Primary-running flag at control bit 3, timer flag at timer bit 6.
// - Reset starts in primary Run with primary flag set, unless two-speed and primary not ready.
// - Select 01 moves to timer, stops primary, sets timer flag only.
// - Select 01 with timer oscillator disabled does not enter secondary.
// - Timer enabled but not oscillating withholds clocks until it starts.
// - Timer to primary: stay on timer until primary ready, timer keeps on.
// - Select hi bit 1 picks internal; low bit ignored; primary stops.
// - Internal to primary waits for primary ready; control bits unchanged.
// - Internal oscillator keeps running after leaving it if WDT or monitor.
// - Entering or leaving internal mode always incurs the switch pause.
// - Idle bit at control bit 7, select field at bits 1:0, writable.
module pmcs_ctrl
    import pmcs_pkg::*;
(
    input  wire logic       clk,             // 40 MHz system clock
    input  wire logic       sys_rst,         // Synchronous reset
    input  wire logic       ctl_wr,          // Control register write
    input  wire logic [7:0] ctl_wdata,       // Control write data
    input  wire logic       sleep_exec,      // Sleep instruction pulse
    input  wire logic       wake_req,        // Wake event pulse
    input  wire logic       two_speed_en,    // Two-speed start-up strap
    input  wire logic       timer_osc_enable,// Timer oscillator enable
    input  wire logic       wdt_en,          // Watchdog enabled
    input  wire logic       fscm_en,         // Fail-safe monitor enabled
    input  wire logic       pri_osc,         // Primary oscillator level
    input  wire logic       tmr_osc,         // Timer oscillator level
    input  wire logic       int_osc,         // Internal oscillator level
    input  wire logic       pri_ready,       // Primary start-up complete
    output logic [7:0]      osc_control_reg, // Control register readback
    output logic            timer_osc_running_flag, // Timer source active
    output logic [2:0]      src_gate_en,     // Per-source gate {int,tmr,pri}
    output logic            cpu_clk_en,      // CPU clock enable
    output logic            periph_clk_en,   // Peripheral clock enable
    output logic            pri_osc_on,      // Primary oscillator power
    output logic            int_osc_on       // Internal oscillator power
);
    // ------------------------------------------------------------
    // Oscillator edge detection
    // ------------------------------------------------------------
    logic [2:0] osc_lvl;
    logic [2:0] osc_rise;
    assign osc_lvl = {int_osc, tmr_osc, pri_osc};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            pmcs_edge_sync u_sync (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .osc_in   (osc_lvl[g]),
                .osc_rise (osc_rise[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic       idle_enable_q;
    logic [1:0] clock_select_q;
    logic       primary_running_flag_q;
    logic       tmr_flag_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_enable_q  <= CTL_RESET[CTL_IDLE_BIT];
            clock_select_q <= CTL_RESET[CTL_SEL_HI:CTL_SEL_LO];
        end else if (ctl_wr) begin
            idle_enable_q  <= ctl_wdata[CTL_IDLE_BIT];
            clock_select_q <= ctl_wdata[CTL_SEL_HI:CTL_SEL_LO];
        end
    end

    // Requested source: hi bit wins, lo bit ignored
    pmcs_src_e req_src;
    always_comb begin
        if (clock_select_q[CTL_SEL_HI]) begin
            req_src = PMCS_SRC_INT;
        end else if (clock_select_q == SEL_TIMER) begin
            req_src = PMCS_SRC_TMR;
        end else begin
            req_src = PMCS_SRC_PRI;
        end
    end

    // ------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------
    pmcs_state_e state_q;
    pmcs_src_e   cur_src_q;
    pmcs_src_e   new_src_q;
    logic [2:0]  cnt_q;
    logic        idle_q;

    // Target usable now: timer needs enable, primary needs ready
    logic tgt_ok;
    always_comb begin
        case (req_src)
            PMCS_SRC_TMR: tgt_ok = timer_osc_enable;
            PMCS_SRC_PRI: tgt_ok = pri_ready;
            default:      tgt_ok = 1'b1;
        endcase
    end

    logic switch_go;
    assign switch_go = (req_src != cur_src_q) && tgt_ok;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q   <= PMCS_RUN;
            cur_src_q <= PMCS_SRC_PRI;
            new_src_q <= PMCS_SRC_PRI;
            cnt_q     <= 3'h0;
            idle_q    <= 1'b0;
        end else begin
            case (state_q)
                PMCS_RUN: begin
                    if (sleep_exec) begin
                        idle_q  <= idle_enable_q;
                        if (!idle_enable_q) begin
                            state_q <= PMCS_SLEEP;
                        end
                    end else if (wake_req) begin
                        idle_q <= 1'b0;
                    end else if (switch_go && !idle_q) begin
                        new_src_q <= req_src;
                        cnt_q     <= 3'h0;
                        state_q   <= PMCS_OLD;
                    end
                end
                PMCS_OLD: begin
                    if (osc_rise[cur_src_q]) begin
                        if (cnt_q == OLD_CYCLES - 3'h1) begin
                            cnt_q   <= 3'h0;
                            state_q <= PMCS_WAIT;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                PMCS_WAIT: begin
                    if (osc_rise[new_src_q]) begin
                        if (cnt_q == NEW_CYCLES - 3'h1) begin
                            cnt_q   <= 3'h0;
                            state_q <= PMCS_NEW;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                PMCS_NEW: begin
                    cur_src_q <= new_src_q;
                    state_q   <= PMCS_RUN;
                end
                PMCS_SLEEP: begin
                    if (wake_req) begin
                        idle_q  <= 1'b0;
                        state_q <= PMCS_RUN;
                    end
                end
                default: state_q <= PMCS_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            primary_running_flag_q <= 1'b1;
            tmr_flag_q             <= 1'b0;
        end else if (state_q == PMCS_SLEEP) begin
            primary_running_flag_q <= 1'b0;
            tmr_flag_q             <= 1'b0;
        end else if (two_speed_en && cur_src_q == PMCS_SRC_PRI
                     && !pri_ready) begin
            primary_running_flag_q <= 1'b0;
        end else if (state_q == PMCS_NEW) begin
            primary_running_flag_q <= (new_src_q == PMCS_SRC_PRI);
            tmr_flag_q             <= (new_src_q == PMCS_SRC_TMR);
        end else if (state_q == PMCS_RUN && cur_src_q == PMCS_SRC_PRI) begin
            primary_running_flag_q <= pri_ready;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_control_reg        <= CTL_RESET;
            timer_osc_running_flag <= 1'b0;
        end else begin
            osc_control_reg <= {idle_enable_q, 3'h0,
                                primary_running_flag_q, 1'b0,
                                clock_select_q};
            timer_osc_running_flag <= tmr_flag_q;
        end
    end

    // Gate one source at a time; none during the switch gap
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_gate_en   <= 3'h1;
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
        end else begin
            case (state_q)
                PMCS_RUN, PMCS_OLD: begin
                    src_gate_en <= 3'h1 << cur_src_q;
                end
                PMCS_NEW: begin
                    src_gate_en <= 3'h1 << new_src_q;
                end
                default: src_gate_en <= 3'h0;
            endcase
            cpu_clk_en    <= (state_q == PMCS_RUN) && !idle_q
                             && !(sleep_exec);
            periph_clk_en <= ((state_q == PMCS_RUN) || (state_q == PMCS_OLD)
                             || (state_q == PMCS_NEW))
                             && !(sleep_exec && !idle_enable_q);
        end
    end

    // Oscillator power
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pri_osc_on <= 1'b1;
            int_osc_on <= 1'b1;
        end else if (state_q == PMCS_SLEEP) begin
            pri_osc_on <= 1'b0;
            int_osc_on <= wdt_en || fscm_en;
        end else begin
            pri_osc_on <= (req_src == PMCS_SRC_PRI)
                          || (cur_src_q == PMCS_SRC_PRI);
            int_osc_on <= (req_src == PMCS_SRC_INT)
                          || (cur_src_q == PMCS_SRC_INT)
                          || (new_src_q == PMCS_SRC_INT)
                          || wdt_en || fscm_en;
        end
    end

    // Two arms kept for clarity sleep_exec alone enters.
    // control bits are never written by the sequencer.

endmodule // pmcs_ctrl

// [verification/pmcs_core_model.sv]
/* Oscillator sources and CPU-core requests for the clock controller.
   Assumes the bench clock and pri_osc_on from the device. */
`timescale 1ns/1ps
module pmcs_core_model (
    input  wire logic       clk,        // System clock
    input  wire logic       pri_osc_on, // Primary power from device
    input  wire logic       tmr_run,    // Timer crystal oscillating
    output logic            pri_osc,    // Primary level
    output logic            tmr_osc,    // Timer level
    output logic            int_osc,    // Internal level
    output logic            ctl_wr,     // Control write pulse
    output logic [7:0]      ctl_wdata,  // Control write data
    output logic            sleep_exec  // Sleep instruction pulse
);
    initial begin
        pri_osc = 1'b0;
        tmr_osc = 1'b0;
        int_osc = 1'b0;
        ctl_wr = 1'b0;
        ctl_wdata = 8'h00;
        sleep_exec = 1'b0;
    end
    // Stopped sources stand still low
    always #50 pri_osc = pri_osc_on ? ~pri_osc : 1'b0;
    always #100 tmr_osc = tmr_run ? ~tmr_osc : 1'b0;
    always #80 int_osc = ~int_osc;

    task automatic wr(input logic [7:0] d);
        @(posedge clk) #2;
        ctl_wr = 1'b1;
        ctl_wdata = d;
        @(posedge clk) #2;
        ctl_wr = 1'b0;
        ctl_wdata = ~d;
    endtask

    task automatic slp();
        @(posedge clk) #2;
        sleep_exec = 1'b1;
        @(posedge clk) #2;
        sleep_exec = 1'b0;
    endtask
endmodule // pmcs_core_model

// [verification/pmcs_ctrl_assertions.sv]
/* Concurrent checks on the controller ports.
   Assumes the bench issues sleep only in Run and spaces writes. */
`timescale 1ns/1ps
module pmcs_ctrl_checker (
    input wire logic       clk,                    // Clock
    input wire logic       sys_rst,                // Reset
    input wire logic       ctl_wr,                 // Write pulse
    input wire logic [7:0] ctl_wdata,              // Write data
    input wire logic       sleep_exec,             // Sleep pulse
    input wire logic       wdt_en,                 // Watchdog on
    input wire logic       fscm_en,                // Monitor on
    input wire logic       timer_osc_enable,       // Timer enable
    input wire logic       pri_ready,              // Primary ready
    input wire logic [7:0] osc_control_reg,        // Readback
    input wire logic       timer_osc_running_flag, // Timer flag
    input wire logic [2:0] src_gate_en,            // Gates
    input wire logic       cpu_clk_en,             // CPU enable
    input wire logic       periph_clk_en,          // Periph enable
    input wire logic       pri_osc_on,             // Primary power
    input wire logic       int_osc_on              // Internal power
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_gate_onehot: assert property ($onehot0(src_gate_en))
        else $error("two source gates open");
    a_gate_break: assert property ($changed(src_gate_en) &&
        $past(src_gate_en) != 3'h0 |-> src_gate_en == 3'h0)
        else $error("gate moved without a gap");
    a_gap_length: assert property ($fell(|src_gate_en) |->
        (src_gate_en == 3'h0) [*3]) else $error("gap too short");
    a_sleep_stop: assert property (sleep_exec && !osc_control_reg[7]
        |=> !cpu_clk_en && !periph_clk_en ##1
        src_gate_en == 3'h0 && !pri_osc_on) else $error("sleep not entered");
    a_idle_cpu: assert property (sleep_exec && osc_control_reg[7]
        |=> !cpu_clk_en && periph_clk_en) else $error("idle wrong");
    a_flags_one: assert property (osc_control_reg[3] &&
        timer_osc_running_flag |=> !(osc_control_reg[3] &&
        timer_osc_running_flag)) else $error("both flags held");
    a_tmr_refuse: assert property (!timer_osc_enable &&
        !timer_osc_running_flag |=> !timer_osc_running_flag &&
        !src_gate_en[1]) else $error("timer entered while disabled");
    a_tmr_entry: assert property ($rose(src_gate_en[1]) |-> ##[0:4]
        (timer_osc_running_flag && !osc_control_reg[3] && !pri_osc_on))
        else $error("timer entry flags wrong");
    a_pri_wait: assert property (!pri_ready && src_gate_en != 3'h1
        |=> src_gate_en != 3'h1) else $error("primary before ready");
    a_int_kept: assert property ((wdt_en || fscm_en) [*2] |->
        int_osc_on) else $error("internal stopped while needed");
    a_ctl_write: assert property (ctl_wr |-> ##2
        osc_control_reg[7] == $past(ctl_wdata[7], 2) &&
        osc_control_reg[1:0] == $past(ctl_wdata[1:0], 2) &&
        osc_control_reg[6:4] == 3'h0 && !osc_control_reg[2])
        else $error("control readback wrong");
    a_ctl_hold: assert property (!$past(ctl_wr) &&
        !$past(ctl_wr, 2) |-> $stable({osc_control_reg[7],
        osc_control_reg[1:0]})) else $error("control bits moved");

    cover property (sleep_exec && !osc_control_reg[7]);
    cover property ($rose(src_gate_en[1]));
    cover property ($rose(src_gate_en[2]));
endmodule // pmcs_ctrl_checker

// [verification/pmcs_ctrl_tb.sv]
/* Self-checking bench for the clock controller.
   Assumes the core model and checker files compile first. */
`timescale 1ns/1ps
bind pmcs_ctrl pmcs_ctrl_checker chk_i (.clk, .sys_rst, .ctl_wr,
    .ctl_wdata, .sleep_exec, .wdt_en, .fscm_en, .timer_osc_enable,
    .pri_ready, .osc_control_reg, .timer_osc_running_flag, .src_gate_en,
    .cpu_clk_en, .periph_clk_en, .pri_osc_on, .int_osc_on);
module pmcs_ctrl_tb;
    import pmcs_pkg::*;
    logic clk, sys_rst, wake_req, tmr_en, wdt_en, fscm_en, pri_ready;
    logic tmr_run, pri_osc, tmr_osc, int_osc, ctl_wr, sleep_exec;
    logic tmr_flag, cpu_en, per_en, pri_on, int_on;
    logic [7:0] ctl_wdata, ctl_reg;
    logic [2:0] gate;
    logic [31:0] seed = 32'h02BDADE6;
    logic [8:0] expq[$];
    int err_count = 0, compares = 0, gap;
    event obs;

    pmcs_ctrl dut (.clk, .sys_rst, .ctl_wr, .ctl_wdata, .sleep_exec,
        .wake_req, .two_speed_en(1'b0), .timer_osc_enable(tmr_en), .wdt_en,
        .fscm_en, .pri_osc, .tmr_osc, .int_osc, .pri_ready,
        .osc_control_reg(ctl_reg), .timer_osc_running_flag(tmr_flag),
        .src_gate_en(gate), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .pri_osc_on(pri_on), .int_osc_on(int_on));
    pmcs_core_model core (.clk, .pri_osc_on(pri_on), .tmr_run, .pri_osc,
        .tmr_osc, .int_osc, .ctl_wr, .ctl_wdata, .sleep_exec);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------
    // Checking
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [8:0] s, e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [8:0] pk(input logic f, input logic [2:0] g,
        input logic c, p, o, b);
        return {f, g, c, p, o, 1'b1, b};
    endfunction
    task automatic exp(input logic [8:0] e);
        expq.push_back(e);
        ->obs;
    endtask
    initial forever begin
        @(obs);
        chk("state", {tmr_flag, gate, cpu_en, per_en, pri_on, int_on,
            ctl_reg[CTL_PRIMARY_RUN_MODE]}, expq.pop_front());
    end

    // ----------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------
    function automatic logic [7:0] wd(input logic i, input logic [1:0] s);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        wdt_en = seed[7];
        fscm_en = ~seed[7];
        return {i, seed[4:0], s};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wait_gate(input logic [2:0] g);
        int n;
        n = 0;
        gap = 0;
        while (gate !== g && n < 2000) begin
            cyc(1);
            n++;
            if (gate === 3'h0) gap++;
        end
        if (n == 2000) chk("gate wait", {6'h0, gate}, {6'h0, g});
        cyc(4);
    endtask
    task automatic wake();
        cyc(10);
        wake_req = 1'b1;
        cyc(1);
        wake_req = 1'b0;
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        {sys_rst, wake_req, tmr_en, tmr_run, wdt_en, fscm_en} = 6'h21;
        pri_ready = 1'b1;
        cyc(8);
        sys_rst = 1'b0;
        cyc(3);
        exp(pk(0, 3'h1, 1, 1, 1, 1));
        core.wr(wd(0, 2'h1));
        cyc(60);
        exp(pk(0, 3'h1, 1, 1, 1, 1));
        tmr_en = 1'b1;
        cyc(60);
        tmr_run = 1'b1;
        wait_gate(3'h2);
        exp(pk(1, 3'h2, 1, 1, 0, 0));
        $display("test timer entry done");
        core.wr(wd(1, 2'h1));
        core.slp();
        cyc(4);
        exp(pk(1, 3'h2, 0, 1, 0, 0));
        wake();
        cyc(6);
        pri_ready = 1'b0;
        core.wr(wd(0, 2'h0));
        cyc(60);
        exp(pk(1, 3'h2, 1, 1, 1, 0));
        pri_ready = 1'b1;
        wait_gate(3'h1);
        exp(pk(0, 3'h1, 1, 1, 1, 1));
        $display("test timer exit done");
        for (int s = 3; s >= 2; s--) begin
            core.wr(wd(0, s[1:0]));
            wait_gate(3'h4);
            chk("gap", {8'h0, gap >= 12}, 9'h1);
            exp(pk(0, 3'h4, 1, 1, 0, 0));
            core.wr(wd(0, 2'h0));
            wait_gate(3'h1);
            exp(pk(0, 3'h1, 1, 1, 1, 1));
        end
        $display("test internal done");
        core.slp();
        cyc(4);
        exp(pk(0, 3'h0, 0, 0, 0, 0));
        wake();
        wait_gate(3'h1);
        exp(pk(0, 3'h1, 1, 1, 1, 1));
        $display("test sleep done");
        cyc(2);
        finish_test();
    end
endmodule // pmcs_ctrl_tb
